// *** hw/tcc_pkg.sv ***
// Shared constants, register map and filter decode for the timer channel conditioning block.
package tcc_pkg;

    // ----
    // Register map
    // ----
    localparam logic [7:0]  ADDR_MODE_FIRST  = 8'h00;
    localparam logic [7:0]  ADDR_MODE_SECOND = 8'h04;
    localparam logic [7:0]  ADDR_CMP_CH3     = 8'h08;
    localparam logic [7:0]  ADDR_CMP_CH4     = 8'h0C;
    localparam logic [7:0]  ADDR_STATUS      = 8'h10;
    localparam logic [15:0] MODE_RESET       = 16'h0000;
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;

    // ----
    // Field layout within one byte-wide half of a mode register
    // ----
    localparam int HALF_W     = 8;
    localparam int SEL_LSB    = 0;
    localparam int PSC_LSB    = 2;
    localparam int FLT_LSB    = 4;
    localparam int FAST_BIT   = 2;
    localparam int SHADOW_BIT = 3;
    localparam int OCTRL_LSB  = 4;
    localparam int CLR_BIT    = 7;
    localparam int STAT_RAW_LSB = 4;

    // ----
    // Codes
    // ----
    localparam logic [1:0] SEL_OUTPUT    = 2'h0;
    localparam logic [1:0] SEL_OWN_PIN   = 2'h1;
    localparam logic [1:0] SEL_NEIGHBOUR = 2'h2;
    localparam logic [1:0] SEL_TRIGGER   = 2'h3;

    localparam logic [2:0] OC_DISCONNECT = 3'h0;
    localparam logic [2:0] OC_SET_MATCH  = 3'h1;
    localparam logic [2:0] OC_CLR_MATCH  = 3'h2;
    localparam logic [2:0] OC_TOGGLE     = 3'h3;
    localparam logic [2:0] OC_FORCE_LOW  = 3'h4;
    localparam logic [2:0] OC_FORCE_HIGH = 3'h5;
    localparam logic [2:0] OC_PWM_A      = 3'h6;
    localparam logic [2:0] OC_PWM_B      = 3'h7;

    // Slave trigger selections below this value are internal trigger inputs.
    localparam logic [2:0] TRIG_SEL_EXT_FIRST = 3'h4;
    localparam int         DIV_W              = 5;

    // ----
    // Filter decode
    // ----
    typedef struct packed {
        logic       bypass;
        logic [2:0] div_log2;
        logic [3:0] count;
    } tcc_flt_cfg_s;

    function automatic tcc_flt_cfg_s flt_decode(input logic [3:0] code);
        tcc_flt_cfg_s c;
        c = '{bypass: 1'b0, div_log2: 3'h0, count: 4'h1};
        unique case (code)
            4'h0: c.bypass = 1'b1;
            4'h1: c.count = 4'h2;
            4'h2: c.count = 4'h4;
            4'h3: c.count = 4'h8;
            4'h4: c = '{1'b0, 3'h1, 4'h6};
            4'h5: c = '{1'b0, 3'h1, 4'h8};
            4'h6: c = '{1'b0, 3'h2, 4'h6};
            4'h7: c = '{1'b0, 3'h2, 4'h8};
            4'h8: c = '{1'b0, 3'h3, 4'h6};
            4'h9: c = '{1'b0, 3'h3, 4'h8};
            4'hA: c = '{1'b0, 3'h4, 4'h5};
            4'hB: c = '{1'b0, 3'h4, 4'h6};
            4'hC: c = '{1'b0, 3'h4, 4'h8};
            4'hD: c = '{1'b0, 3'h5, 4'h5};
            4'hE: c = '{1'b0, 3'h5, 4'h6};
            4'hF: c = '{1'b0, 3'h5, 4'h8};
        endcase
        return c;
    endfunction

endpackage

// *** hw/tcc_edge_filter.sv ***
// Digital edge filter for one timer input pin.
`timescale 1ns/100ps
module tcc_edge_filter (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic                  sample_en,
    input  wire tcc_pkg::tcc_flt_cfg_s cfg,
    input  wire logic                  raw_in,
    output logic                       filtered
);

    logic [3:0] run;

    // ----
    // Confirmation counter
    // ----
    // R19: restart on mismatch
    // R7: pass after N samples
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            filtered <= 1'b0;
            run      <= 4'h0;
        end else if (cfg.bypass) begin
            filtered <= raw_in;
            run      <= 4'h0;
        end else if (sample_en) begin
            if (raw_in == filtered) begin
                run <= 4'h0;
            end else if (run + 4'h1 >= cfg.count) begin
                filtered <= raw_in;
                run      <= 4'h0;
            end else begin
                run <= run + 4'h1;
            end
        end
    end

endmodule

// *** hw/tcc_channel_cond.sv ***
// Input conditioning and capture prescaling for four timer channels, compare output control for channels 3 and 4.
//
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps

// Overview of operation
// R1: Channel 1 select: 00 output, 01 own pin, 10 pin 2, 11 trigger line.
// R2: Channel 2 select: 00 output, 01 own pin, 10 pin 1, 11 trigger line.
// R3: Channel 4 select: 00 output, 01 own pin, 10 pin 3, 11 trigger line.
// R4: Channel 3 select: 00 output, 01 own pin, 10 pin 4, 11 trigger line.
// R5: Trigger-line capture source works only when an internal trigger is selected.
// R6: Software changes select fields only while the channel is disabled.
// R7: An edge passes the filter after N confirming samples.
// R8: Code 0 bypasses; codes 1 to 3 sample every clock with N 2, 4, 8.
// R9: Codes 4,5 sample at clock/2, codes 6,7 at clock/4, N 6 and 8.
// R10: Codes 8,9 at /8; 10 to 12 at /16; 13 to 15 at /32.
// R11: Prescaler captures every 1st, 2nd, 4th or 8th active edge.
// R12: Prescaler edge count clears while the channel enable is low.
// R13: Input view: filter and prescaler fields at bits 15:12, 11:10, 7:4, 3:2.
// R14: Output view: clear, control, shadow and fast bits for channels 3 and 4.
// R15: Output control codes set, clear, toggle, force or PWM the raw output.
// R16: Shadow enable defers compare value writes to the overflow event.
// R17: Clear enable drops the raw output while the external clear is high.
// R18: Fast enable in PWM applies the match level on a trigger event.
// R19: Filter count restarts whenever a sample disagrees with the candidate.
module tcc_channel_cond #(
    parameter int CNT_W = 16
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [7:0]       s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    input  wire logic [7:0]       s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    input  wire logic [3:0]       pin_raw_input,
    input  wire logic [3:0]       ch_enable_bit,
    input  wire logic             internal_trigger_line,
    input  wire logic [2:0]       slave_trigger_select,
    input  wire logic [CNT_W-1:0] counter_value,
    input  wire logic             count_down,
    input  wire logic             overflow_event,
    input  wire logic             trigger_event,
    input  wire logic             external_clear_input,
    output logic [3:0]            capture_event,
    output logic [1:0]            ch_raw_compare_output
);

    // ----
    // Elaboration check
    // ----
    if (CNT_W < 2 || CNT_W > 32) begin : g_bad_width
        $error("CNT_W must lie between 2 and 32.");
    end

    logic [15:0]          channel_mode_first;
    logic [15:0]          channel_mode_second;
    logic [CNT_W-1:0]     cmp_written [2];
    logic [CNT_W-1:0]     cmp_active [2];
    logic [3:0]           pin_filtered;
    logic [3:0]           capture_input;
    logic [3:0]           capture_prev;
    logic [2:0]           edge_count [4];
    logic [tcc_pkg::DIV_W-1:0] div_count;
    logic                 trig_source_ok;
    logic                 wr_take;
    logic                 rd_take;
    logic [31:0]          wr_mask;
    logic [31:0]          next_rdata;
    logic [1:0]           next_rresp;

    // ----
    // AXI4-Lite write channel
    // ----
    // Address and data are taken together, so the slave never buffers one alone.
    assign wr_take = s_axi_awvalid && s_axi_awready;
    assign rd_take = s_axi_arvalid && s_axi_arready;

    always_comb begin
        wr_mask = 32'h0000_0000;
        for (int b = 0; b < 4; b++) begin
            if (s_axi_wstrb[b]) begin
                wr_mask[8*b +: 8] = 8'hFF;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready  <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= tcc_pkg::RESP_OKAY;
        end else if (wr_take) begin
            s_axi_bvalid <= 1'b1;
            unique case (s_axi_awaddr)
                tcc_pkg::ADDR_MODE_FIRST, tcc_pkg::ADDR_MODE_SECOND,
                tcc_pkg::ADDR_CMP_CH3, tcc_pkg::ADDR_CMP_CH4,
                tcc_pkg::ADDR_STATUS: s_axi_bresp <= tcc_pkg::RESP_OKAY;
                default: s_axi_bresp <= tcc_pkg::RESP_SLVERR;
            endcase
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ----
    // Mode registers
    // ----
    // R13: input view fields
    // R14: output view fields
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            channel_mode_first  <= tcc_pkg::MODE_RESET;
            channel_mode_second <= tcc_pkg::MODE_RESET;
        end else if (wr_take) begin
            if (s_axi_awaddr == tcc_pkg::ADDR_MODE_FIRST) begin
                channel_mode_first <= (channel_mode_first & ~wr_mask[15:0])
                                    | (s_axi_wdata[15:0] & wr_mask[15:0]);
            end
            if (s_axi_awaddr == tcc_pkg::ADDR_MODE_SECOND) begin
                channel_mode_second <= (channel_mode_second & ~wr_mask[15:0])
                                     | (s_axi_wdata[15:0] & wr_mask[15:0]);
            end
        end
    end

    // ----
    // AXI4-Lite read channel
    // ----
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_rresp = tcc_pkg::RESP_OKAY;
        unique case (s_axi_araddr)
            tcc_pkg::ADDR_MODE_FIRST:  next_rdata[15:0] = channel_mode_first;
            tcc_pkg::ADDR_MODE_SECOND: next_rdata[15:0] = channel_mode_second;
            tcc_pkg::ADDR_CMP_CH3:     next_rdata[CNT_W-1:0] = cmp_written[0];
            tcc_pkg::ADDR_CMP_CH4:     next_rdata[CNT_W-1:0] = cmp_written[1];
            tcc_pkg::ADDR_STATUS: begin
                next_rdata[3:0] = pin_filtered;
                next_rdata[tcc_pkg::STAT_RAW_LSB +: 2] = ch_raw_compare_output;
            end
            default: next_rresp = tcc_pkg::RESP_SLVERR;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= tcc_pkg::RESP_OKAY;
        end else if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= next_rdata;
            s_axi_rresp  <= next_rresp;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // ----
    // Sampling clock divider
    // ----
    // The dead-time clock equals aclk here; slower rates are enable pulses.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            div_count <= '0;
        end else begin
            div_count <= div_count + 1'b1;
        end
    end

    // R5: trigger source gating
    assign trig_source_ok = slave_trigger_select < tcc_pkg::TRIG_SEL_EXT_FIRST;

    // ----
    // Per-channel input path
    // ----
    // Channels 1,2 live in the first register and 3,4 in the second; each
    // pair shares one register, so the neighbour of channel i is i^1.
    for (genvar i = 0; i < 4; i++) begin : g_ch
        logic [7:0]                half;
        logic [1:0]                sel;
        logic [1:0]                psc;
        tcc_pkg::tcc_flt_cfg_s     cfg;
        logic [tcc_pkg::DIV_W-1:0] mask;
        logic                      sample_en;

        assign half = (i < 2) ? channel_mode_first[(i%2)*tcc_pkg::HALF_W +: 8]
                              : channel_mode_second[(i%2)*tcc_pkg::HALF_W +: 8];
        assign sel  = half[tcc_pkg::SEL_LSB +: 2];
        assign psc  = half[tcc_pkg::PSC_LSB +: 2];
        // R8: code 0 and clock-rate codes
        // R9: divide by 2 and 4
        // R10: divide by 8, 16, 32
        assign cfg  = tcc_pkg::flt_decode(half[tcc_pkg::FLT_LSB +: 4]);
        assign mask = tcc_pkg::DIV_W'((32'h1 << cfg.div_log2) - 32'h1);
        assign sample_en = (div_count & mask) == mask;

        tcc_edge_filter u_filter (
            .aclk      (aclk),
            .aresetn   (aresetn),
            .sample_en (sample_en),
            .cfg       (cfg),
            .raw_in    (pin_raw_input[i]),
            .filtered  (pin_filtered[i])
        );

        // R1: channel 1 routing
        // R2: channel 2 routing
        // R3: channel 4 routing
        // R4: channel 3 routing
        always_comb begin
            unique case (sel)
                tcc_pkg::SEL_OUTPUT:    capture_input[i] = 1'b0;
                tcc_pkg::SEL_OWN_PIN:   capture_input[i] = pin_filtered[i];
                tcc_pkg::SEL_NEIGHBOUR: capture_input[i] = pin_filtered[i^1];
                tcc_pkg::SEL_TRIGGER:   capture_input[i] = internal_trigger_line
                                                         && trig_source_ok;
            endcase
        end

        // R11: capture prescaler
        // R12: clear while disabled
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                capture_prev[i]  <= 1'b0;
                edge_count[i]    <= 3'h0;
                capture_event[i] <= 1'b0;
            end else begin
                capture_prev[i]  <= capture_input[i];
                capture_event[i] <= 1'b0;
                if (!ch_enable_bit[i]) begin
                    edge_count[i] <= 3'h0;
                end else if (capture_input[i] && !capture_prev[i]
                             && sel != tcc_pkg::SEL_OUTPUT) begin
                    if (edge_count[i] == 3'((4'h1 << psc) - 4'h1)) begin
                        edge_count[i]    <= 3'h0;
                        capture_event[i] <= 1'b1;
                    end else begin
                        edge_count[i] <= edge_count[i] + 3'h1;
                    end
                end
            end
        end
    end

    // ----
    // Compare outputs for channels 3 and 4
    // ----
    for (genvar k = 0; k < 2; k++) begin : g_cmp
        logic [7:0] half;
        logic [2:0] octrl;
        logic       match;
        logic       pwm_level;
        logic [7:0] addr;

        assign half  = channel_mode_second[k*tcc_pkg::HALF_W +: 8];
        assign octrl = half[tcc_pkg::OCTRL_LSB +: 3];
        assign match = counter_value == cmp_active[k];
        assign addr  = (k == 0) ? tcc_pkg::ADDR_CMP_CH3 : tcc_pkg::ADDR_CMP_CH4;
        assign pwm_level = count_down ? !(cmp_active[k] < counter_value)
                                      : (cmp_active[k] > counter_value);

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                cmp_written[k] <= '0;
            end else if (wr_take && s_axi_awaddr == addr) begin
                cmp_written[k] <= (cmp_written[k] & ~wr_mask[CNT_W-1:0])
                                | (s_axi_wdata[CNT_W-1:0] & wr_mask[CNT_W-1:0]);
            end
        end

        // R16: shadow compare value
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                cmp_active[k] <= '0;
            end else if (!half[tcc_pkg::SHADOW_BIT] || overflow_event) begin
                cmp_active[k] <= cmp_written[k];
            end
        end

        // R15: output control modes
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                ch_raw_compare_output[k] <= 1'b0;
            // R17: external clear
            end else if (half[tcc_pkg::CLR_BIT] && external_clear_input) begin
                ch_raw_compare_output[k] <= 1'b0;
            // R18: fast trigger response
            end else if (half[tcc_pkg::FAST_BIT] && trigger_event
                         && (octrl == tcc_pkg::OC_PWM_A || octrl == tcc_pkg::OC_PWM_B)) begin
                ch_raw_compare_output[k] <= (octrl == tcc_pkg::OC_PWM_A) ? count_down
                                                                         : !count_down;
            end else begin
                unique case (octrl)
                    tcc_pkg::OC_DISCONNECT: ch_raw_compare_output[k] <= 1'b0;
                    tcc_pkg::OC_SET_MATCH:  if (match) ch_raw_compare_output[k] <= 1'b1;
                    tcc_pkg::OC_CLR_MATCH:  if (match) ch_raw_compare_output[k] <= 1'b0;
                    tcc_pkg::OC_TOGGLE: begin
                        if (match) ch_raw_compare_output[k] <= !ch_raw_compare_output[k];
                    end
                    tcc_pkg::OC_FORCE_LOW:  ch_raw_compare_output[k] <= 1'b0;
                    tcc_pkg::OC_FORCE_HIGH: ch_raw_compare_output[k] <= 1'b1;
                    tcc_pkg::OC_PWM_A:      ch_raw_compare_output[k] <= pwm_level;
                    tcc_pkg::OC_PWM_B:      ch_raw_compare_output[k] <= !pwm_level;
                endcase
            end
        end
    end

endmodule

// *** sim/tcc_pin_model.sv ***
// Model of the pins and the trigger source that feed the channel inputs.
`timescale 1ns/100ps
module tcc_pin_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [4:0] fire,
    input  wire logic [8:0] hold,
    output logic [3:0]      pin_raw_input,
    output logic            internal_trigger_line
);
    logic [8:0] left;
    logic [4:0] lines;

    // Lines rest low between pulses, so a stale level never looks like a new edge.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            left <= 9'h000;
        end else if (fire != 5'h00) begin
            left  <= hold;
            lines <= fire;
        end else if (left != 9'h000) begin
            left <= left - 9'h001;
        end
    end
    assign {internal_trigger_line, pin_raw_input} = (left != 9'h000) ? lines : 5'h00;
endmodule

// *** sim/tcc_cc_props.sv ***
// Concurrent checks on the ports of the channel conditioning block.
`timescale 1ns/100ps
module tcc_cc_props #(
    parameter int CNT_W = 16
) (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic [3:0]  pin_raw_input,
    input wire logic [3:0]  ch_enable_bit,
    input wire logic [2:0]  slave_trigger_select,
    input wire logic [3:0]  capture_event
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence all_off_s;
        (ch_enable_bit == 4'h0) [*3];
    endsequence
    sequence quiet_src_s;
        (pin_raw_input == 4'h0 && slave_trigger_select[2]) [*8];
    endsequence
    a_aw_w_pair: assert property (s_axi_awready |-> s_axi_wready)
        else $error("w apart from aw");
    a_b_after_take: assert property (s_axi_awready |=> s_axi_bvalid)
        else $error("b late");
    a_r_after_take: assert property (s_axi_arready |=> s_axi_rvalid)
        else $error("r late");
    a_err_data_zero: assert property (s_axi_rvalid && s_axi_rresp == tcc_pkg::RESP_SLVERR |-> s_axi_rdata == 32'h0000_0000)
        else $error("error data");
    a_r_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("r not held");
    a_cap_one_cycle: assert property ((capture_event & $past(capture_event)) == 4'h0)
        else $error("long capture");
    a_cap_disabled: assert property (all_off_s |-> capture_event == 4'h0)
        else $error("capture disabled");
    a_trig_quiet: assert property (quiet_src_s |-> capture_event == 4'h0)
        else $error("capture no source");
endmodule
bind tcc_channel_cond tcc_cc_props #(.CNT_W(CNT_W)) u_props (
    .aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .pin_raw_input,
    .ch_enable_bit, .slave_trigger_select, .capture_event
);

// *** sim/testbench.sv ***
// Self-checking bench for the timer channel conditioning block.
`timescale 1ns/100ps
module testbench;
    logic            aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic            s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic            s_axi_rready, internal_trigger_line, external_clear_input;
    logic [7:0]      s_axi_awaddr, s_axi_araddr;
    logic [31:0]     s_axi_wdata, s_axi_rdata;
    logic [3:0]      s_axi_wstrb, ch_enable_bit, capture_event, pin_raw_input;
    logic [1:0]      s_axi_bresp, s_axi_rresp, ch_raw_compare_output, bq;
    logic [2:0]      slave_trigger_select;
    logic [15:0]     counter_value = 16'h0000;
    logic            count_down = 1'b0, overflow_event = 1'b0, trigger_event = 1'b0;
    logic [4:0]      pf;
    logic [8:0]      ph;
    logic [3:0][3:0] cc;
    int              n_fail = 0, compares = 0;
    logic [3:0]      fc [4] = '{4'h3, 4'h5, 4'hA, 4'hF};
    int              hs [4] = '{5, 10, 50, 200};
    int              hl [4] = '{12, 24, 90, 300};

    tcc_channel_cond dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .pin_raw_input, .ch_enable_bit, .internal_trigger_line,
        .slave_trigger_select, .counter_value, .count_down, .overflow_event, .trigger_event,
        .external_clear_input, .capture_event, .ch_raw_compare_output
    );
    tcc_pin_model u_pins (
        .aclk, .aresetn, .fire(pf), .hold(ph), .pin_raw_input, .internal_trigger_line
    );

    always #10 aclk = ~aclk;
    always @(posedge aclk) begin
        for (int i = 0; i < 4; i++) begin
            if (capture_event[i] === 1'b1) cc[i] <= cc[i] + 4'h1;
        end
    end

    // ----
    // Tasks
    // ----
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
        do @(posedge aclk); while (s_axi_awready !== 1'b1);
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h1;
        do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
        bq = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do @(posedge aclk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    // mode fields change only while the channels are disabled.
    task automatic cfg(input logic [31:0] d1, input logic [31:0] d2, input logic [3:0] e);
        ch_enable_bit <= 4'h0;
        wr(tcc_pkg::ADDR_MODE_FIRST, d1);
        wr(tcc_pkg::ADDR_MODE_SECOND, d2);
        ch_enable_bit <= e;
    endtask
    task automatic pulse(input string what, input logic [4:0] m, input int h, input logic [15:0] exp);
        logic [3:0][3:0] b;
        logic [3:0][3:0] d;
        b = cc;
        pf <= m;
        ph <= h[8:0];
        @(posedge aclk);
        pf <= 5'h00;
        repeat (h + 300) @(posedge aclk);
        for (int i = 0; i < 4; i++) d[i] = cc[i] - b[i];
        chk(what, {16'h0000, d}, {16'h0000, exp});
        $display("test %s done", what);
    endtask
    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // ----
    // Sequence of tests
    // ----
    initial begin
        logic [31:0] v;
        logic [1:0]  r;
        {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 6'h00;
        {s_axi_rready, external_clear_input, ch_enable_bit, slave_trigger_select, pf} = 14'h0000;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, ph, cc} = 77'h0;
        s_axi_wstrb = 4'hF;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(tcc_pkg::ADDR_MODE_SECOND, v, r);
        chk("mode second reset", v, 32'h0000_0000);
        rd(8'h14, v, r);
        chk("unmapped resp", {30'h0, r}, {30'h0, tcc_pkg::RESP_SLVERR});
        wr(8'h14, 32'h0000_0000);
        chk("unmapped wr", {30'h0, bq}, {30'h0, tcc_pkg::RESP_SLVERR});
        wr(tcc_pkg::ADDR_MODE_FIRST, 32'h0000_FEDC);
        rd(tcc_pkg::ADDR_MODE_FIRST, v, r);
        chk("mode first rw", v, 32'h0000_FEDC);
        wr(tcc_pkg::ADDR_MODE_SECOND, 32'h0000_5050);
        repeat (2) @(posedge aclk);
        chk("force high", {30'h0, ch_raw_compare_output}, 32'h0000_0003);
        external_clear_input <= 1'b1;
        wr(tcc_pkg::ADDR_MODE_SECOND, 32'h0000_40D0);
        repeat (2) @(posedge aclk);
        chk("clear and low", {30'h0, ch_raw_compare_output}, 32'h0000_0000);
        external_clear_input <= 1'b0;
        wr(tcc_pkg::ADDR_CMP_CH3, 32'h0000_0005);
        wr(tcc_pkg::ADDR_MODE_SECOND, 32'h0000_0074);
        trigger_event <= 1'b1;
        @(posedge aclk);
        trigger_event <= 1'b0;
        @(negedge aclk);
        chk("fast trigger", {30'h0, ch_raw_compare_output}, 32'h0000_0001);
        $display("test registers done");
        cfg(32'h0000_0202, 32'h0000_0202, 4'hF);
        pulse("pin1 to ch2", 5'h01, 4, 16'h0010);
        pulse("pin2 to ch1", 5'h02, 4, 16'h0001);
        pulse("pin3 to ch4", 5'h04, 4, 16'h1000);
        pulse("pin4 to ch3", 5'h08, 4, 16'h0100);
        cfg(32'h0000_0101, 32'h0000_0101, 4'hF);
        pulse("own pins", 5'h0F, 4, 16'h1111);
        cfg(32'h0000_0303, 32'h0000_0303, 4'hF);
        pulse("trigger internal", 5'h10, 4, 16'h1111);
        slave_trigger_select <= 3'h4;
        pulse("trigger external", 5'h10, 4, 16'h0000);
        for (int k = 0; k < 4; k++) begin
            cfg({24'h0, fc[k], 4'h1}, 32'h0000_0000, 4'h1);
            pulse("filter short", 5'h01, hs[k], 16'h0000);
            pulse("filter long", 5'h01, hl[k], 16'h0001);
        end
        for (int p = 0; p < 4; p++) begin
            cfg(32'(p * 4 + 1), 32'h0000_0000, 4'h1);
            for (int j = 1; j < (1 << p); j++) pulse("prescale early", 5'h01, 4, 16'h0000);
            pulse("prescale due", 5'h01, 4, 16'h0001);
        end
        cfg(32'h0000_0005, 32'h0000_0000, 4'h1);
        pulse("prescale first", 5'h01, 4, 16'h0000);
        ch_enable_bit <= 4'h0;
        @(posedge aclk);
        ch_enable_bit <= 4'h1;
        pulse("prescale cleared", 5'h01, 4, 16'h0000);
        pulse("prescale after clear", 5'h01, 4, 16'h0001);
        tally_and_finish();
    end
    initial begin
        repeat (40000) @(posedge aclk);
        n_fail++;
        tally_and_finish();
    end
endmodule
